/* File: include/sic_pkg.sv */
// Purpose: shared constants and types for the configuration register pair
// Assumes: 8-bit host data, 11-bit host i/o address
// Notes:   reset values are power-up values only
package sic_pkg;
    // host i/o ports: index port sits one below the data port
    localparam logic [10:0] SIC_DATA_PORT     = 11'h3F1;
    localparam logic [10:0] SIC_DATA_PORT_ALT = 11'h371;
    localparam logic [10:0] SIC_INDEX_PORT    = 11'h3F0;
    localparam logic [10:0] SIC_INDEX_PORT_ALT = 11'h370;
    // register indices
    localparam logic [7:0]  SIC_IDX_SERIAL    = 8'h02;
    localparam logic [7:0]  SIC_IDX_FLOPPY    = 8'h03;
    // power-up values; the floppy value is wider than the register
    localparam logic [7:0]  SIC_SERIAL_RST    = 8'h88;
    localparam logic [11:0] SIC_FLOPPY_RST_PRINTED = 12'h780;
    localparam logic [7:0]  SIC_FLOPPY_RST    = SIC_FLOPPY_RST_PRINTED[7:0];
    // writable bit masks; other bits read as zero
    localparam logic [7:0]  SIC_SERIAL_MASK   = 8'h88;
    localparam logic [7:0]  SIC_FLOPPY_MASK   = 8'hF7;
    // field positions
    localparam int SIC_B_UART1  = 3;
    localparam int SIC_B_UART2  = 7;
    localparam int SIC_B_GAME   = 0;
    localparam int SIC_B_ENH2   = 1;
    localparam int SIC_B_PIN_LO = 2;
    localparam int SIC_B_DEN1   = 4;
    localparam int SIC_B_MODE   = 5;
    localparam int SIC_B_PIN_HI = 7;
    // base address below which a device leaves address decode
    localparam logic [10:0] SIC_DECODE_FLOOR  = 11'h100;

    // interface mode from bits 6:5
    typedef enum logic [1:0] {
        SIC_MODE_M30  = 2'b00,
        SIC_MODE_PS   = 2'b01,
        SIC_MODE_RSV  = 2'b10,
        SIC_MODE_AT   = 2'b11
    } sic_mode_t;

    // shared pin function from bits 7,2
    typedef enum logic [1:0] {
        SIC_PIN_DRIVE2  = 2'b00,
        SIC_PIN_ADDR    = 2'b01,
        SIC_PIN_IRQ_B   = 2'b10
    } sic_pin_t;

    // one host i/o request, synchronous to clock
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [10:0] addr;
        logic [7:0]  wdata;
    } sic_io_req_t;
endpackage : sic_pkg

/* File: rtl/sic_config_regs.sv */
// Purpose: serial power and floppy/pin mode configuration registers
// Assumes: host i/o request strobes are synchronous to clock
// Notes:   rst is the power-up reset; no hardware reset input exists
//
// Function
// - serial power register answers only in config mode with index 02h
// - serial power register loads 88h at power-up
// - serial bits 0-2 and 4-6 are read-only zero
// - serial bit 3 low powers down the primary serial port
// - serial bit 7 low powers down the secondary serial port
// - power-down disables device and pins, keeps base decode registers
// - device leaves decode only when base below 100h
// - floppy register answers only in config mode with index 03h
// - floppy register takes 80h, the low byte of printed default 780h, at power-up
// - floppy bit 1 selects normal or enhanced floppy mode 2
// - floppy bit 4 high holds second density pin high
// - floppy bits 6:5 select one of three interface modes or reserved
// - registers reached via data port 3F1h or alternate 371h
// - defaults load at power-up only, not on hardware reset
`timescale 1ns/100ps
module sic_config_regs (
    input  wire logic                 clock,
    input  wire logic                 rst,
    input  wire sic_pkg::sic_io_req_t io_req,
    input  wire logic                 config_mode,
    input  wire logic                 alt_port,
    input  wire logic [10:0]          uart1_base,
    input  wire logic [10:0]          uart2_base,
    input  wire logic                 density_in,
    output logic [7:0]                rd_data,
    output logic                      rd_valid,
    output logic [7:0]                config_index_select,
    output logic                      uart1_enable,
    output logic                      uart2_enable,
    output logic                      uart1_decode_en,
    output logic                      uart2_decode_en,
    output logic                      enhanced_mode2,
    output sic_pkg::sic_mode_t        interface_mode,
    output logic                      interface_mode_low_bit,
    output logic                      second_density_output,
    output logic                      game_port_chip_select_en,
    output sic_pkg::sic_pin_t         shared_pin_function
);
    import sic_pkg::*;

    logic [7:0] serial_q;
    logic [7:0] floppy_q;
    logic [7:0] index_q;
    logic [7:0] rd_data_q;
    logic       rd_valid_q;
    logic       hit_index;
    logic       hit_data;
    logic       sel_serial;
    logic       sel_floppy;

    ////////////////////////////////////////////////////////////////////////
    // merge a write into a register, keeping reserved bits at zero
    function automatic logic [7:0] merge(input logic [7:0] wd,
                                         input logic [7:0] mask);
        merge = wd & mask;
    endfunction : merge

    ////////////////////////////////////////////////////////////////////////
    // port decode; alternate setting moves both ports
    always_comb begin
        hit_index = io_req.addr == (alt_port ? SIC_INDEX_PORT_ALT
                                             : SIC_INDEX_PORT);
        hit_data  = io_req.addr == (alt_port ? SIC_DATA_PORT_ALT
                                             : SIC_DATA_PORT);
        sel_serial = config_mode && hit_data
                     && index_q == SIC_IDX_SERIAL;
        sel_floppy = config_mode && hit_data
                     && index_q == SIC_IDX_FLOPPY;
    end

    // index register, writable only in config mode
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            index_q <= 8'h00;
        end else if (config_mode && hit_index && io_req.wr) begin
            index_q <= io_req.wdata;
        end
    end

    // only power-up reset touches these: no other reset path exists
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            serial_q <= SIC_SERIAL_RST;
        end else if (sel_serial && io_req.wr) begin
            serial_q <= merge(io_req.wdata, SIC_SERIAL_MASK);
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            floppy_q <= SIC_FLOPPY_RST;
        end else if (sel_floppy && io_req.wr) begin
            floppy_q <= merge(io_req.wdata, SIC_FLOPPY_MASK);
        end
    end

    // read data is registered: answer one cycle after the strobe
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rd_data_q  <= 8'h00;
            rd_valid_q <= 1'b0;
        end else begin
            rd_valid_q <= io_req.rd && config_mode && (hit_data || hit_index);
            if (sel_serial) begin
                rd_data_q <= serial_q & SIC_SERIAL_MASK;
            end else if (sel_floppy) begin
                rd_data_q <= floppy_q & SIC_FLOPPY_MASK;
            end else if (config_mode && hit_index) begin
                rd_data_q <= index_q;
            end else begin
                rd_data_q <= 8'h00;   // unknown index reads zero here
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // device controls; decode stays tied to base, not to power
    always_comb begin
        uart1_enable    = serial_q[SIC_B_UART1];
        uart2_enable    = serial_q[SIC_B_UART2];
        uart1_decode_en = uart1_base >= SIC_DECODE_FLOOR;
        uart2_decode_en = uart2_base >= SIC_DECODE_FLOOR;
        enhanced_mode2  = floppy_q[SIC_B_ENH2];
        interface_mode  = sic_mode_t'(floppy_q[SIC_B_MODE +: 2]);
        interface_mode_low_bit = floppy_q[SIC_B_MODE];
        second_density_output  = floppy_q[SIC_B_DEN1] | density_in;
        game_port_chip_select_en = floppy_q[SIC_B_GAME];
        if (!floppy_q[SIC_B_PIN_HI]) begin
            shared_pin_function = SIC_PIN_DRIVE2;
        end else if (!floppy_q[SIC_B_PIN_LO]) begin
            shared_pin_function = SIC_PIN_ADDR;
        end else begin
            shared_pin_function = SIC_PIN_IRQ_B;
        end
    end

    assign rd_data             = rd_data_q;
    assign rd_valid            = rd_valid_q;
    assign config_index_select = index_q;

    ////////////////////////////////////////////////////////////////////////
    // checks
    property p_serial_gate;
        @(posedge clock) disable iff (rst)
        (io_req.wr && !(config_mode && hit_data
            && index_q == SIC_IDX_SERIAL)) |=> $stable(serial_q);
    endproperty
    a_serial_gate: assert property (p_serial_gate)
        else $error("serial register changed without selection");

    property p_floppy_gate;
        @(posedge clock) disable iff (rst)
        (io_req.wr && !(config_mode && hit_data
            && index_q == SIC_IDX_FLOPPY)) |=> $stable(floppy_q);
    endproperty
    a_floppy_gate: assert property (p_floppy_gate)
        else $error("floppy register changed without selection");

    property p_serial_rsv;
        @(posedge clock) disable iff (rst)
        (rd_valid && $past(sel_serial)) |-> (rd_data & 8'h77) == 8'h00;
    endproperty
    a_serial_rsv: assert property (p_serial_rsv)
        else $error("serial reserved bits read nonzero");

    property p_floppy_rsv;
        @(posedge clock) disable iff (rst)
        (rd_valid && $past(sel_floppy)) |-> !rd_data[3];
    endproperty
    a_floppy_rsv: assert property (p_floppy_rsv)
        else $error("floppy reserved bit read nonzero");

    property p_uart1_write;
        @(posedge clock) disable iff (rst)
        (sel_serial && io_req.wr) |=> uart1_enable == $past(io_req.wdata[3]);
    endproperty
    a_uart1_write: assert property (p_uart1_write)
        else $error("primary power bit did not follow write");

    property p_uart2_write;
        @(posedge clock) disable iff (rst)
        (sel_serial && io_req.wr) |=> uart2_enable == $past(io_req.wdata[7]);
    endproperty
    a_uart2_write: assert property (p_uart2_write)
        else $error("secondary power bit did not follow write");

    property p_density_hold;
        @(posedge clock) disable iff (rst)
        floppy_q[SIC_B_DEN1] |-> second_density_output;
    endproperty
    a_density_hold: assert property (p_density_hold)
        else $error("density pin not held high");

    property p_pin_fn;
        @(posedge clock) disable iff (rst)
        (sel_floppy && io_req.wr && !io_req.wdata[7])
            |=> shared_pin_function == SIC_PIN_DRIVE2;
    endproperty
    a_pin_fn: assert property (p_pin_fn)
        else $error("shared pin not drive-two input");

    property p_decode;
        @(posedge clock) disable iff (rst)
        (!uart1_enable && uart1_base >= SIC_DECODE_FLOOR) |-> uart1_decode_en;
    endproperty
    a_decode: assert property (p_decode)
        else $error("powered-down device lost decode");

    // a data port read in config mode always gets its one-cycle answer
    property p_rd_answer;
        @(posedge clock) disable iff (rst)
        (io_req.rd && config_mode && hit_data) |=> rd_valid;
    endproperty
    a_rd_answer: assert property (p_rd_answer)
        else $error("data port read not answered");

    // outside config mode the host must see no answer at all
    property p_rd_refuse;
        @(posedge clock) disable iff (rst)
        (io_req.rd && !config_mode) |=> !rd_valid;
    endproperty
    a_rd_refuse: assert property (p_rd_refuse)
        else $error("read answered outside config mode");
endmodule : sic_config_regs

/* File: verification/sic_config_regs_bench.sv */
// Purpose: self-checking bench for the configuration register pair
// Assumes: inputs change 1 ns after the rising edge
// Notes:   rst is the only reset, so defaults are seen once
`timescale 1ns/100ps
module sic_config_regs_bench;
    import sic_pkg::*;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic [10:0] b1 = 11'h3F8;
    logic [10:0] b2 = 11'h2F8;
    logic        den = 1'b0;
    logic [10:0] ip = SIC_INDEX_PORT;
    logic [10:0] dp = SIC_DATA_PORT;
    logic [7:0]  rdv;
    logic        rv;
    logic [7:0]  idx;
    logic        e1, e2, d1, d2, enh, lo, den_o, gm;
    sic_io_req_t req;
    logic        cfg, alt;
    sic_mode_t   md;
    sic_pin_t    pf;
    logic [7:0]  v;
    logic        ok;
    logic [7:0]  vals [6] = '{8'h00, 8'h2B, 8'h54, 8'hFF, 8'h84, 8'hC0};
    int          fails = 0;
    int          comparisons = 0;

    always #2.5 clock = ~clock;

    sic_host_model u_sic_host_model (.clock(clock), .rd_data(rdv),
        .rd_valid(rv), .io_req(req), .config_mode(cfg), .alt_port(alt));

    sic_config_regs u_sic_config_regs (.clock(clock), .rst(rst),
        .io_req(req), .config_mode(cfg), .alt_port(alt), .uart1_base(b1),
        .uart2_base(b2), .density_in(den), .rd_data(rdv), .rd_valid(rv),
        .config_index_select(idx), .uart1_enable(e1), .uart2_enable(e2),
        .uart1_decode_en(d1), .uart2_decode_en(d2), .enhanced_mode2(enh),
        .interface_mode(md), .interface_mode_low_bit(lo),
        .second_density_output(den_o), .game_port_chip_select_en(gm),
        .shared_pin_function(pf));

    ////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : end_sim

    task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic wreg(input logic [7:0] i, input logic [7:0] d);
        u_sic_host_model.wr(ip, i);
        u_sic_host_model.wr(dp, d);
    endtask : wreg

    // a missing answer is fatal: later reads would be meaningless
    task automatic rchk(input logic [7:0] i, input logic [7:0] exp);
        u_sic_host_model.wr(ip, i);
        u_sic_host_model.rd(dp, v, ok);
        if (ok !== 1'b1) begin
            fails++;
            end_sim();
        end
        chk(v, exp);
    endtask : rchk

    // watchdog against a hung sequence
    initial begin
        repeat (20000) @(posedge clock);
        fails++;
        end_sim();
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge clock);
        #1 rst = 1'b0;
        u_sic_host_model.set_mode(1'b1, 1'b0);
        rchk(SIC_IDX_SERIAL, 8'h88);
        rchk(SIC_IDX_FLOPPY, 8'h80);
        wreg(SIC_IDX_SERIAL, 8'hFF);
        rchk(SIC_IDX_SERIAL, 8'h88);
        wreg(SIC_IDX_SERIAL, 8'h08);
        chk({e1, e2}, 2'b10);
        wreg(SIC_IDX_SERIAL, 8'h80);
        chk({e1, e2}, 2'b01);
        b1 = 11'h0FF;
        b2 = 11'h100;
        #1 chk({d1, d2}, 2'b01);
        // primary is powered down yet must keep decoding at a valid base
        @(posedge clock);
        #1 b1 = 11'h3F8;
        #1 chk({e1, d1}, 2'b01);
        // floppy fields across every mode and pin function
        foreach (vals[k]) begin
            wreg(SIC_IDX_FLOPPY, vals[k]);
            den = k[0];
            rchk(SIC_IDX_FLOPPY, vals[k] & 8'hF7);
            chk({enh, lo}, {vals[k][1], vals[k][5]});
            chk(md, vals[k][6:5]);
            chk({gm, den_o}, {vals[k][0], vals[k][4] | k[0]});
            chk(pf, vals[k][7] ? (vals[k][2] ? SIC_PIN_IRQ_B : SIC_PIN_ADDR)
                                : SIC_PIN_DRIVE2);
        end
        // outside configuration mode nothing is taken or answered
        u_sic_host_model.set_mode(1'b0, 1'b0);
        wreg(SIC_IDX_SERIAL, 8'h00);
        u_sic_host_model.rd(dp, v, ok);
        chk(ok, 1'b0);
        chk(idx, SIC_IDX_FLOPPY);
        u_sic_host_model.set_mode(1'b1, 1'b0);
        rchk(SIC_IDX_SERIAL, 8'h80);
        rchk(8'h05, 8'h00);
        // the index register reads back on the index port
        u_sic_host_model.rd(ip, v, ok);
        chk({ok, v}, {1'b1, 8'h05});
        chk(idx, 8'h05);
        u_sic_host_model.set_mode(1'b1, 1'b1);
        ip = SIC_INDEX_PORT_ALT;
        dp = SIC_DATA_PORT_ALT;
        rchk(SIC_IDX_FLOPPY, 8'hC0);
        end_sim();
    end
endmodule : sic_config_regs_bench

/* File: verification/sic_host_model.sv */
// Purpose: host model issuing configuration i/o cycles
// Assumes: strobes change 1 ns after a rising edge
// Notes:   a read with no answer returns ok low
`timescale 1ns/100ps
module sic_host_model
    import sic_pkg::*;
(
    input  wire logic      clock,
    input  wire logic [7:0] rd_data,
    input  wire logic      rd_valid,
    output sic_io_req_t    io_req,
    output logic           config_mode,
    output logic           alt_port
);
    // idle bus at time zero, outside configuration mode
    initial begin
        io_req = '{1'b0, 1'b0, 11'h000, 8'h00};
        config_mode = 1'b0;
        alt_port = 1'b0;
    end

    // mode levels are owned here; callers change them just after an edge
    task automatic set_mode(input logic c, input logic a);
        config_mode = c;
        alt_port = a;
    endtask : set_mode

    ////////////////////////////////////////////////////////////////////////
    // one-cycle write strobe; released bus shows inverted values
    task automatic wr(input logic [10:0] a, input logic [7:0] d);
        @(posedge clock);
        #1 io_req = '{1'b0, 1'b1, a, d};
        @(posedge clock);
        #1 io_req = '{1'b0, 1'b0, ~a, ~d};
    endtask : wr

    // read strobe, then a bounded watch for the answer pulse
    task automatic rd(input logic [10:0] a, output logic [7:0] d,
                      output logic ok);
        ok = 1'b0;
        d = 8'h00;
        @(posedge clock);
        #1 io_req = '{1'b1, 1'b0, a, 8'h00};
        @(posedge clock);
        #1 io_req = '{1'b0, 1'b0, ~a, 8'hFF};
        repeat (3) begin
            if (!ok && rd_valid === 1'b1) begin
                ok = 1'b1;
                d = rd_data;
            end
            @(posedge clock);
            #1;
        end
    endtask : rd
endmodule : sic_host_model
